// ===== rtl/msts_defs.vh
// Purpose: constants for the multi-sensor trigger sync block
// Assumes: shared time base ticks once per core_clk cycle
// Notes: byte addresses on the wishbone slave, one word each
`ifndef MSTS_DEFS_VH
`define MSTS_DEFS_VH
// register byte offsets
`define MSTS_REG_CTRL 8'h00
`define MSTS_REG_GDELAY 8'h04
`define MSTS_REG_TOFFS 8'h08
`define MSTS_REG_IPERIOD 8'h0C
`define MSTS_REG_STATUS 8'h10
`define MSTS_REG_EVT 8'h14
`define MSTS_REG_MASK 8'h18
`define MSTS_REG_STATCNT 8'h1C
// control fields
`define MSTS_CTRL_SYNC_EN 0
`define MSTS_CTRL_SLAVE 1
`define MSTS_CTRL_TRIG_ON 2
`define MSTS_CTRL_SIMUL 3
`define MSTS_CTRL_INVERT 4
`define MSTS_CTRL_GROUP_LO 8
`define MSTS_CTRL_GROUP_HI 11
`define MSTS_CTRL_STATSEL_LO 12
`define MSTS_CTRL_STATSEL_HI 13
// status fields
`define MSTS_ST_ROLE 0
`define MSTS_ST_PENDING 1
`define MSTS_ST_ARMED 2
`define MSTS_ST_SIM_OFF 3
// event bits (also statistic selector codes)
`define MSTS_EVT_TRIG 0
`define MSTS_EVT_SENT 1
`define MSTS_EVT_EXPOSE 2
`define MSTS_EVT_LATE 3
`define MSTS_EVT_W 4
// reset values
`define MSTS_CTRL_RST 32'h0000_3000
`define MSTS_TOFFS_RST 32'h0000_0000
`define MSTS_MASK_RST 4'h0
// timing: worst transport at 1 Gbps is 90 us, 40 cycles per us
`define MSTS_GDELAY_US 32'h0000_005A
`define MSTS_CLK_MHZ 32'h0000_0028
`define MSTS_GDELAY_RST (`MSTS_GDELAY_US * `MSTS_CLK_MHZ)
// internal trigger period, 1 ms
`define MSTS_IPERIOD_US 32'h0000_03E8
`define MSTS_IPERIOD_RST (`MSTS_IPERIOD_US * `MSTS_CLK_MHZ)
`endif

// ===== rtl/msts_edge_in.v
// Purpose: bring the trigger pin into core_clk and find rising edges
// Assumes: pin is asynchronous to core_clk
// Notes: toggling invert may itself produce one edge
`timescale 1ns/1ps
module msts_edge_in (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // pin and option
  input wire pinLevel,
  input wire invert,
  // result
  output reg risePulse
);
  reg sync1;
  reg sync2;
  reg lastLevel;
  wire level;

  // inversion is applied before the edge is judged
  assign level = sync2 ^ invert;

  always @(posedge core_clk) begin
    if (!rst_n) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      lastLevel <= 1'b0;
      risePulse <= 1'b0;
    end else begin
      sync1 <= pinLevel;
      sync2 <= sync1;
      lastLevel <= level;
      risePulse <= level & ~lastLevel;
    end
  end
endmodule // msts_edge_in

// ===== rtl/msts_trigger_sync.v
// Purpose: master/slave profile trigger synchronisation for a sensor group
// Assumes: timeNow is the group-wide time base, one tick per cycle
// Notes: message link and packet streamer are logic on core_clk
// Contract
// - master starts group sequence on its trigger
// - master sends timing messages to the slaves
// - slave acquires a profile per master message; code drops late messages and other groups' messages
// - master waits group delay before exposure possible
// - no exposure before group delay after trigger
// - sequential mode adds each sensor's own offset
// - simultaneous mode exposes all at group delay
// - message waits for current packet to finish
// - slave counts late messages in selectable statistic
// - simultaneous refused while master trigger is off
// - external trigger on rising edge, optional inversion
`timescale 1ns/1ps
`include "msts_defs.vh"
module msts_trigger_sync (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // trigger pin and shared time base
  input wire extTrigger,
  input wire [31:0] timeNow,
  // message transmit toward the switch
  input wire pktBusy,
  output reg txMsgValid,
  output reg [31:0] txMsgTime,
  output reg [31:0] txMsgDelay,
  output reg txMsgSimul,
  output reg [3:0] txMsgGroup,
  // message receive from the switch
  input wire rxMsgValid,
  input wire [31:0] rxMsgTime,
  input wire [31:0] rxMsgDelay,
  input wire rxMsgSimul,
  input wire [3:0] rxMsgGroup,
  // acquisition and status
  output reg exposeStart,
  output reg groupRoleStatus,
  output reg irq
);
  localparam M_IDLE = 1'b0;
  localparam M_HOLD = 1'b1;

  // true once now has reached target, wrap-safe
  function reached;
    input [31:0] target;
    input [31:0] now;
    reg [31:0] diff;
    begin
      diff = now - target;
      reached = ~diff[31];
    end
  endfunction

  // byte-lane merge for partial writes
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] sel;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[8*i +: 8] = data[8*i +: 8];
        end
      end
    end
  endfunction

  reg [31:0] ctrl;
  reg [31:0] groupDelay;
  reg [31:0] trigOffset;
  reg [31:0] intPeriod;
  reg [`MSTS_EVT_W-1:0] evt;
  reg [`MSTS_EVT_W-1:0] evtMask;
  reg [31:0] statCount;
  reg [31:0] intCount;
  reg mState;
  reg [31:0] trigTime;
  reg armed;
  reg [31:0] target;
  reg [`MSTS_EVT_W-1:0] next_evt;
  reg [31:0] rdData;

  wire syncEn = ctrl[`MSTS_CTRL_SYNC_EN];
  wire isSlave = ctrl[`MSTS_CTRL_SLAVE];
  wire trigOn = ctrl[`MSTS_CTRL_TRIG_ON];
  wire [3:0] groupNumber = ctrl[`MSTS_CTRL_GROUP_HI:`MSTS_CTRL_GROUP_LO];
  wire [1:0] statSel = ctrl[`MSTS_CTRL_STATSEL_HI:`MSTS_CTRL_STATSEL_LO];
  // simultaneous needs a profile trigger delay, so it needs trigger on
  wire simulOk = ctrl[`MSTS_CTRL_SIMUL] & trigOn;
  wire simOff = ctrl[`MSTS_CTRL_SIMUL] & ~trigOn;

  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr = busReq & wb_we_i;
  wire extRise;
  wire intTick;
  wire masterTrig;
  wire rxOurs;
  wire [31:0] rxTarget;
  wire rxLate;
  wire [31:0] mTarget;
  wire sendNow;
  wire fire;
  wire statHit;

  msts_edge_in msts_edge_in_i (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinLevel(extTrigger),
    .invert(ctrl[`MSTS_CTRL_INVERT]),
    .risePulse(extRise)
  );

  // internal trigger runs only while the external trigger is off
  assign intTick = ~trigOn & (intCount >= intPeriod - 32'h0000_0001);
  assign masterTrig = syncEn & ~isSlave & (trigOn ? extRise : intTick);

  // own exposure: group delay, plus offset unless simultaneous
  assign mTarget = trigTime + groupDelay + (simulOk ? 32'h0000_0000 :
    trigOffset);
  // a switch to slave role or sync off drops a message still waiting
  assign sendNow = (mState == M_HOLD) & ~pktBusy & syncEn & ~isSlave;

  // slave side, all times taken from the master trigger event
  assign rxOurs = syncEn & isSlave & rxMsgValid & (rxMsgGroup == groupNumber);
  assign rxTarget = rxMsgTime + rxMsgDelay + (rxMsgSimul ? 32'h0000_0000 :
    trigOffset);
  assign rxLate = reached(rxTarget, timeNow);

  assign fire = armed & reached(target, timeNow);

  // master trigger handling and message launch
  always @(posedge core_clk) begin
    if (!rst_n) begin
      mState <= M_IDLE;
      trigTime <= 32'h0000_0000;
      txMsgValid <= 1'b0;
      txMsgTime <= 32'h0000_0000;
      txMsgDelay <= 32'h0000_0000;
      txMsgSimul <= 1'b0;
      txMsgGroup <= 4'h0;
      intCount <= 32'h0000_0000;
    end else begin
      txMsgValid <= 1'b0;
      if (trigOn || intTick) begin
        intCount <= 32'h0000_0000;
      end else begin
        intCount <= intCount + 32'h0000_0001;
      end
      if (masterTrig) begin
        // a newer trigger replaces one still waiting for the link
        trigTime <= timeNow;
        mState <= M_HOLD;
      end else if (sendNow) begin
        txMsgValid <= 1'b1;
        txMsgTime <= trigTime;
        txMsgDelay <= groupDelay;
        txMsgSimul <= simulOk;
        txMsgGroup <= groupNumber;
        mState <= M_IDLE;
      end else if (!syncEn || isSlave) begin
        mState <= M_IDLE;
      end else begin
        mState <= mState;
      end
    end
  end

  // exposure scheduler, one pending start at a time
  always @(posedge core_clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
      target <= 32'h0000_0000;
      exposeStart <= 1'b0;
    end else begin
      exposeStart <= fire;
      if (masterTrig) begin
        armed <= 1'b0;
      end else if (mState == M_HOLD && sendNow) begin
        armed <= 1'b1;
        target <= mTarget;
      end else if (rxOurs && !rxLate) begin
        armed <= 1'b1;
        target <= rxTarget;
      end else if (fire || !syncEn) begin
        armed <= 1'b0;
      end
      // a late message leaves the schedule alone: it is dropped
      if (rxOurs && rxLate) begin
        armed <= armed & ~fire;
      end
    end
  end

  // events; hardware set wins over a software clear
  always @* begin
    next_evt = evt;
    if (busWr && wb_adr_i == `MSTS_REG_EVT && wb_sel_i[0]) begin
      next_evt = evt & ~wb_dat_i[`MSTS_EVT_W-1:0];
    end
    if (masterTrig) begin
      next_evt[`MSTS_EVT_TRIG] = 1'b1;
    end
    if (sendNow) begin
      next_evt[`MSTS_EVT_SENT] = 1'b1;
    end
    if (fire) begin
      next_evt[`MSTS_EVT_EXPOSE] = 1'b1;
    end
    if (rxOurs && rxLate) begin
      next_evt[`MSTS_EVT_LATE] = 1'b1;
    end
  end

  assign statHit = (statSel == 2'h0 && masterTrig) ||
    (statSel == 2'h1 && sendNow) || (statSel == 2'h2 && fire) ||
    (statSel == 2'h3 && rxOurs && rxLate);

  // register file
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl <= `MSTS_CTRL_RST;
      groupDelay <= `MSTS_GDELAY_RST;
      trigOffset <= `MSTS_TOFFS_RST;
      intPeriod <= `MSTS_IPERIOD_RST;
      evtMask <= `MSTS_MASK_RST;
      evt <= {`MSTS_EVT_W{1'b0}};
      statCount <= 32'h0000_0000;
      irq <= 1'b0;
      groupRoleStatus <= 1'b0;
    end else begin
      evt <= next_evt;
      irq <= |(next_evt & evtMask);
      groupRoleStatus <= isSlave;
      if (busWr && wb_adr_i == `MSTS_REG_STATCNT) begin
        statCount <= statHit ? 32'h0000_0001 : 32'h0000_0000;
      end else if (statHit) begin
        statCount <= statCount + 32'h0000_0001;
      end
      if (busWr) begin
        case (wb_adr_i)
          `MSTS_REG_CTRL: ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
          `MSTS_REG_GDELAY: groupDelay <= merge(groupDelay, wb_dat_i,
            wb_sel_i);
          `MSTS_REG_TOFFS: trigOffset <= merge(trigOffset, wb_dat_i,
            wb_sel_i);
          `MSTS_REG_IPERIOD: intPeriod <= merge(intPeriod, wb_dat_i,
            wb_sel_i);
          `MSTS_REG_MASK: begin
            if (wb_sel_i[0]) begin
              evtMask <= wb_dat_i[`MSTS_EVT_W-1:0];
            end
          end
          default: ;
        endcase
      end
    end
  end

  always @* begin
    case (wb_adr_i)
      `MSTS_REG_CTRL: rdData = ctrl;
      `MSTS_REG_GDELAY: rdData = groupDelay;
      `MSTS_REG_TOFFS: rdData = trigOffset;
      `MSTS_REG_IPERIOD: rdData = intPeriod;
      `MSTS_REG_STATUS: rdData = {28'h000_0000, simOff, armed,
        mState == M_HOLD, isSlave};
      `MSTS_REG_EVT: rdData = {28'h000_0000, evt};
      `MSTS_REG_MASK: rdData = {28'h000_0000, evtMask};
      `MSTS_REG_STATCNT: rdData = statCount;
      default: rdData = 32'h0000_0000;
    endcase
  end

  // one wait-free answer per request; unmapped reads give zero
  always @(posedge core_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        wb_dat_o <= rdData;
      end
    end
  end
endmodule // msts_trigger_sync

// ===== tb/msts_sync_checker_properties.sv
// Purpose: port assertions for msts_trigger_sync
// Assumes: one clock, rst_n synchronous active low
// Notes: bound below to every instance of the block
`timescale 1ns/1ps
module msts_sync_checker (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // bus, message link, exposure and role status
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire pktBusy,
  input wire txMsgValid,
  input wire [31:0] txMsgTime,
  input wire exposeStart,
  input wire groupRoleStatus
);
  wire wrReq = wb_cyc_i & wb_stb_i & wb_we_i;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_follows_req: assert property (req |-> ##1 wb_ack_o)
    else $error("request not answered");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  a_read_data_held: assert property
    ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved");
  a_tx_not_busy: assert property (txMsgValid |-> !$past(pktBusy))
    else $error("message inside packet");
  a_tx_fields_held: assert property
    ($changed(txMsgTime) |-> txMsgValid)
    else $error("message time moved");
  a_tx_master_only: assert property (txMsgValid |-> !groupRoleStatus)
    else $error("slave sent message");
  a_role_by_write: assert property
    ($changed(groupRoleStatus) |-> $past(wrReq) || $past(wrReq, 2))
    else $error("role changed alone");
  a_expose_pulse: assert property (exposeStart |=> !exposeStart)
    else $error("expose pulse too long");
endmodule // msts_sync_checker
bind msts_trigger_sync msts_sync_checker msts_sync_checker_i (.core_clk,
  .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .pktBusy,
  .txMsgValid, .txMsgTime, .exposeStart, .groupRoleStatus);

// ===== tb/msts_peer_model.sv
// Purpose: peer master sensor seen across the switch
// Assumes: shared time base advances once per core_clk
// Notes: lag holds a message back to model a slow switch
`timescale 1ns/1ps
module msts_peer_model (
  // clock and bench commands
  input wire core_clk,
  input wire sendReq,
  input wire [7:0] lag,
  input wire [31:0] msgDelay,
  input wire msgSimul,
  input wire [3:0] msgGroup,
  // toward the block
  output reg [31:0] timeNow = 32'h0000_0000,
  output reg rxMsgValid = 1'b0,
  output reg [31:0] rxMsgTime = 32'h0000_0000,
  output reg [31:0] rxMsgDelay = 32'h0000_0000,
  output reg rxMsgSimul = 1'b0,
  output reg [3:0] rxMsgGroup = 4'h0
);
  reg [31:0] stamp = 32'h0000_0000;
  reg [7:0] left = 8'h00;
  reg armed = 1'b0;
  always @(posedge core_clk) begin
    timeNow <= timeNow + 32'h0000_0001;
    rxMsgValid <= 1'b0;
    // stale fields scrambled so a late sampler cannot get lucky
    {rxMsgTime, rxMsgDelay, rxMsgSimul, rxMsgGroup} <=
      ~{rxMsgTime, rxMsgDelay, rxMsgSimul, rxMsgGroup};
    if (sendReq) begin
      stamp <= timeNow;
      left <= lag;
      armed <= 1'b1;
    end else if (armed && left != 8'h00) begin
      left <= left - 8'h01;
    end else if (armed) begin
      armed <= 1'b0;
      rxMsgValid <= 1'b1;
      rxMsgTime <= stamp;
      rxMsgDelay <= msgDelay;
      rxMsgSimul <= msgSimul;
      rxMsgGroup <= msgGroup;
    end
  end
endmodule // msts_peer_model

// ===== tb/multi_sensor_trigger_sync_bench.sv
// Purpose: self-checking bench for msts_trigger_sync
// Assumes: peer model supplies time base and messages
// Notes: short delays are written so runs stay brief
`timescale 1ns/1ps
module multi_sensor_trigger_sync_bench;
  reg core_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [7:0] wb_adr_i = 0, lag = 0;
  reg [3:0] wb_sel_i = 0, msgGroup = 0;
  reg [31:0] wb_dat_i = 0, msgDelay = 0, rdata, base;
  reg extTrigger = 0, pktBusy = 0, sendReq = 0, msgSimul = 0;
  wire [31:0] wb_dat_o, timeNow, txMsgTime, txMsgDelay, rxMsgTime, rxMsgDelay;
  wire [3:0] txMsgGroup, rxMsgGroup;
  wire wb_ack_o, txMsgValid, txMsgSimul, rxMsgValid, rxMsgSimul;
  wire exposeStart, groupRoleStatus, irq;
  integer errors = 0, samples_checked = 0;
  always #12.5 core_clk = ~core_clk;
  msts_trigger_sync msts_trigger_sync_i (.core_clk, .rst_n, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .extTrigger, .timeNow, .pktBusy, .txMsgValid, .txMsgTime,
    .txMsgDelay, .txMsgSimul, .txMsgGroup, .rxMsgValid, .rxMsgTime,
    .rxMsgDelay, .rxMsgSimul, .rxMsgGroup, .exposeStart, .groupRoleStatus,
    .irq);
  msts_peer_model msts_peer_model_i (.core_clk, .sendReq, .lag, .msgDelay,
    .msgSimul, .msgGroup, .timeNow, .rxMsgValid, .rxMsgTime, .rxMsgDelay,
    .rxMsgSimul, .rxMsgGroup);
  task final_report;
    begin
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task check(input ok, input [8*8:1] msg);
    begin
      samples_checked = samples_checked + 1;
      if (!ok) begin
        errors = errors + 1;
        $display("CHECK FAILED at %0t: %0s", $time, msg);
      end
    end
  endtask
  task wb(input [7:0] a, input [31:0] d, input w);
    integer n;
    begin
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hF};
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1 && n < 20) begin
        @(posedge core_clk);
        n = n + 1;
      end
      if (n == 20) check(0, "no ack");
      if (n == 20) final_report;
      rdata = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'b00;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      wb(a, 32'h0000_0000, 1'b0);
      check(rdata === e, "read");
    end
  endtask
  // base is the trigger time carried by the last message seen
  task expose(input [31:0] add, input ok);
    integer n;
    begin
      base = 32'hxxxx_xxxx;
      for (n = 0; n < 90 && exposeStart !== 1'b1; n = n + 1) begin
        @(posedge core_clk);
        #1;
        if (txMsgValid === 1'b1) base = txMsgTime;
        if (rxMsgValid === 1'b1) base = rxMsgTime;
      end
      if (ok) check(timeNow === base + add + 32'h0000_0001, "expose");
      else check(n == 90, "stray");
      if (ok && n == 90) begin
        check(1'b0, "timeout");
        final_report;
      end
    end
  endtask
  task slv(input [31:0] dl, input sm, input [3:0] g, input [7:0] lg,
    input [31:0] add, input ok);
    begin
      @(posedge core_clk);
      {msgDelay, msgSimul, msgGroup, lag, sendReq} <= {dl, sm, g, lg, 1'b1};
      @(posedge core_clk);
      sendReq <= 1'b0;
      expose(add, ok);
    end
  endtask
  task irqIs(input v);
    begin
      repeat (2) @(posedge core_clk);
      #1;
      check(irq === v, "irq");
    end
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'h00, 32'h0000_3000);
    rd(8'h04, 32'h0000_0E10);
    rd(8'h20, 32'h0000_0000);
    wb(8'h04, 32'h0000_0014, 1'b1);
    wb(8'h08, 32'h0000_0005, 1'b1);
    wb(8'h0C, 32'h0000_0032, 1'b1);
    wb(8'h00, 32'h0000_0305, 1'b1);
    {pktBusy, extTrigger} <= 2'b11;
    repeat (12) @(posedge core_clk);
    pktBusy <= 1'b0;
    expose(32'h0000_0019, 1'b1);
    check(txMsgDelay === 32'h0000_0014 && txMsgGroup === 4'h3, "fields");
    wb(8'h00, 32'h0000_0315, 1'b1);
    expose(32'h0000_0000, 1'b0);
    @(posedge core_clk);
    extTrigger <= 1'b0;
    expose(32'h0000_0019, 1'b1);
    wb(8'h00, 32'h0000_030D, 1'b1);
    @(posedge core_clk);
    extTrigger <= 1'b1;
    expose(32'h0000_0014, 1'b1);
    check(txMsgSimul === 1'b1, "simul");
    wb(8'h00, 32'h0000_0309, 1'b1);
    expose(32'h0000_0019, 1'b1);
    wb(8'h10, 32'h0000_0000, 1'b0);
    check(rdata[3] === 1'b1, "refused");
    wb(8'h00, 32'h0000_3303, 1'b1);
    repeat (60) @(posedge core_clk);
    check(groupRoleStatus === 1'b1, "role");
    // four master triggers were counted while the statistic chose triggers
    rd(8'h1C, 32'h0000_0004);
    wb(8'h1C, 32'h0000_0000, 1'b1);
    wb(8'h14, 32'h0000_000F, 1'b1);
    wb(8'h18, 32'h0000_0008, 1'b1);
    slv(32'h0000_001E, 1'b0, 4'h3, 8'h00, 32'h0000_0023, 1'b1);
    slv(32'h0000_001E, 1'b1, 4'h3, 8'h00, 32'h0000_001E, 1'b1);
    slv(32'h0000_001E, 1'b0, 4'h2, 8'h00, 32'h0000_0000, 1'b0);
    slv(32'h0000_000A, 1'b0, 4'h3, 8'h28, 32'h0000_0000, 1'b0);
    irqIs(1'b1);
    rd(8'h14, 32'h0000_000C);
    rd(8'h1C, 32'h0000_0001);
    wb(8'h1C, 32'h0000_0000, 1'b1);
    rd(8'h1C, 32'h0000_0000);
    wb(8'h18, 32'h0000_0000, 1'b1);
    irqIs(1'b0);
    wb(8'h18, 32'h0000_0008, 1'b1);
    irqIs(1'b1);
    wb(8'h14, 32'h0000_0008, 1'b1);
    irqIs(1'b0);
    // statistic now counts exposure starts
    wb(8'h00, 32'h0000_2303, 1'b1);
    wb(8'h1C, 32'h0000_0000, 1'b1);
    slv(32'h0000_001E, 1'b1, 4'h3, 8'h00, 32'h0000_001E, 1'b1);
    rd(8'h1C, 32'h0000_0001);
    final_report;
  end
endmodule // multi_sensor_trigger_sync_bench
